// ===== rtl/cmcc_map.vh
// Constants of the configuration memory CRC checker.
// Operation
// - Check each received frame against its frame CRC.
// - Load frames until mismatch or all checked; stop.
// - Store image 32-bit CRC as reference at end.
// - In user mode recompute cell memory CRC repeatedly.
// - Keep checking until reconfiguration request goes low.
// - Cover only configuration cell memory, nothing else.
// - One 32-bit CRC with IEEE 802 polynomial.
// - Zero signature gives error 0, otherwise 1.
// - Reference load instruction accepted only in user mode.
// - Opcode 00 0001 0101 puts reference between TDI, TDO.
// - Error pin push-pull by default, open-drain option.
// - Checking starts automatically on entering user mode.
// - Error holds through next pass, no longer history.
// - Checker clock is oscillator divided by 2^n, n 0..8.
`ifndef CMCC_MAP_VH
`define CMCC_MAP_VH

`define CMCC_IMAGE_POLY 32'h04C11DB7
`define CMCC_IMAGE_INIT 32'hFFFFFFFF
`define CMCC_FRAME_POLY 16'h1021
`define CMCC_FRAME_INIT 16'hFFFF

`define CMCC_LOAD_REF_OPCODE 10'h015
`define CMCC_IR_CAPTURE 10'h001
`define CMCC_IR_BYPASS 10'h3FF
`define CMCC_IR_W 10
`define CMCC_REF_W 32

`define CMCC_CELL_AW 10
`define CMCC_CELL_LAST 10'h3FF
`define CMCC_WORD_W 16

`define CMCC_KIND_DATA 2'h0
`define CMCC_KIND_FRAME_CRC 2'h1
`define CMCC_KIND_IMAGE_CRC 2'h2

`define CMCC_OSC_MHZ 80
`define CMCC_DIV_EXP_MAX 4'h8

`endif

// ===== rtl/cmcc_crc_step.v
// One 16-bit data word folded into a CRC register, MSB first.
module cmcc_crc_step #(
  parameter CW = 32,
  parameter [CW-1:0] POLY = {CW{1'b1}}
) (
  // CRC state in
  input wire [CW-1:0] crc_i,
  // Data word
  input wire [15:0] data_i,
  // CRC state out
  output reg [CW-1:0] crc_o
);

  integer i;
  reg fb;

  always @*
  begin
    fb = 1'b0;
    crc_o = crc_i;
    for (i = 15; i >= 0; i = i - 1)
    begin
      fb = crc_o[CW-1] ^ data_i[i];
      crc_o = {crc_o[CW-2:0], 1'b0} ^ (fb ? POLY : {CW{1'b0}});
    end
  end

endmodule // cmcc_crc_step

// ===== rtl/cmcc_top.v
// Configuration memory CRC checker: frame check, user mode scan, scan-chain access.
`include "cmcc_map.vh"

module cmcc_top (
  // Clock and reset
  input wire clk_i,
  input wire rstn_i,
  // Reconfiguration request pin, active low
  input wire reconfig_request_n_i,
  // Configuration bit stream words
  input wire cfg_valid_i,
  input wire [1:0] cfg_kind_i,
  input wire [31:0] cfg_data_i,
  // Configuration options
  input wire check_en_i,
  input wire open_drain_en_i,
  input wire [3:0] div_exp_i,
  // Configuration cell memory port
  output reg cell_wr_o,
  output reg cell_rd_o,
  output reg [`CMCC_CELL_AW-1:0] cell_addr_o,
  output reg [`CMCC_WORD_W-1:0] cell_wdata_o,
  input wire [`CMCC_WORD_W-1:0] cell_rdata_i,
  // Boundary-scan port
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output reg tdo_o,
  output reg tdo_oe_o,
  // Status
  output reg crc_error_o,
  output reg crc_error_oe_o,
  output reg config_error_o,
  output reg user_mode_o
);

  localparam [2:0] ST_CONFIG = 3'h0;
  localparam [2:0] ST_HALT = 3'h1;
  localparam [2:0] ST_INIT = 3'h2;
  localparam [2:0] ST_USER = 3'h3;
  localparam [2:0] ST_SCAN = 3'h4;
  localparam [3:0] TAP_RESET = 4'h0;
  localparam [3:0] TAP_IDLE = 4'h1;
  localparam [3:0] TAP_SEL_DR = 4'h2;
  localparam [3:0] TAP_CAP_DR = 4'h3;
  localparam [3:0] TAP_SH_DR = 4'h4;
  localparam [3:0] TAP_EX1_DR = 4'h5;
  localparam [3:0] TAP_PA_DR = 4'h6;
  localparam [3:0] TAP_EX2_DR = 4'h7;
  localparam [3:0] TAP_UPD_DR = 4'h8;
  localparam [3:0] TAP_SEL_IR = 4'h9;
  localparam [3:0] TAP_CAP_IR = 4'hA;
  localparam [3:0] TAP_SH_IR = 4'hB;
  localparam [3:0] TAP_EX1_IR = 4'hC;
  localparam [3:0] TAP_PA_IR = 4'hD;
  localparam [3:0] TAP_EX2_IR = 4'hE;
  localparam [3:0] TAP_UPD_IR = 4'hF;
  // Divider mask for a 2^n step period; exponents above the limit are clamped.
  function [7:0] div_mask;
    input [3:0] e;
    reg [3:0] c;
    begin
      c = (e > `CMCC_DIV_EXP_MAX) ? `CMCC_DIV_EXP_MAX : e;
      div_mask = 8'hFF >> (4'h8 - c);
    end
  endfunction
  function [3:0] tap_next;
    input [3:0] s;
    input t;
    begin
      case (s)
        TAP_RESET: tap_next = t ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: tap_next = t ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: tap_next = t ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: tap_next = t ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR: tap_next = t ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: tap_next = t ? TAP_UPD_DR : TAP_PA_DR;
        TAP_PA_DR: tap_next = t ? TAP_EX2_DR : TAP_PA_DR;
        TAP_EX2_DR: tap_next = t ? TAP_UPD_DR : TAP_SH_DR;
        TAP_UPD_DR: tap_next = t ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: tap_next = t ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: tap_next = t ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR: tap_next = t ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: tap_next = t ? TAP_UPD_IR : TAP_PA_IR;
        TAP_PA_IR: tap_next = t ? TAP_EX2_IR : TAP_PA_IR;
        TAP_EX2_IR: tap_next = t ? TAP_UPD_IR : TAP_SH_IR;
        TAP_UPD_IR: tap_next = t ? TAP_SEL_DR : TAP_IDLE;
        default: tap_next = TAP_RESET;
      endcase
    end
  endfunction
  reg [2:0] state_q;
  reg [1:0] rc_sync_q;
  reg [7:0] div_cnt_q;
  reg [15:0] fcrc_q;
  reg [31:0] scrc_q;
  reg [`CMCC_REF_W-1:0] ref_q;
  reg [`CMCC_CELL_AW-1:0] wr_ptr_q;
  reg err_q;
  reg [2:0] tck_sync_q;
  reg [1:0] tms_sync_q;
  reg [1:0] tdi_sync_q;
  reg [3:0] tap_q;
  reg [`CMCC_IR_W-1:0] ir_q;
  reg [`CMCC_IR_W-1:0] ir_sh_q;
  reg [`CMCC_REF_W-1:0] dr_sh_q;
  wire [15:0] fcrc_next;
  wire [31:0] scrc_next;
  wire reconfig;
  wire step;
  wire in_user;
  wire ref_sel;
  wire tck_rise;
  wire tck_fall;
  wire ref_upd;
  assign reconfig = ~rc_sync_q[1];
  assign step = (div_cnt_q == div_mask(div_exp_i));
  assign in_user = (state_q == ST_USER) || (state_q == ST_SCAN);
  assign ref_sel = (ir_q == `CMCC_LOAD_REF_OPCODE) && in_user;
  assign tck_rise = tck_sync_q[1] & ~tck_sync_q[2];
  assign tck_fall = ~tck_sync_q[1] & tck_sync_q[2];
  assign ref_upd = tck_rise && (tap_q == TAP_UPD_DR) && ref_sel;
  cmcc_crc_step #(
    .CW(16),
    .POLY(`CMCC_FRAME_POLY)
  ) u_frame_crc (
    .crc_i(fcrc_q),
    .data_i(cfg_data_i[15:0]),
    .crc_o(fcrc_next)
  );
  // Only the cell memory words feed the image CRC.
  cmcc_crc_step #(
    .CW(32),
    .POLY(`CMCC_IMAGE_POLY)
  ) u_image_crc (
    .crc_i(scrc_q),
    .data_i(cell_rdata_i),
    .crc_o(scrc_next)
  );
  // Pin synchronisers; only the second stage and later are read.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rc_sync_q <= 2'h0;
      tck_sync_q <= 3'h0;
      tms_sync_q <= 2'h3;
      tdi_sync_q <= 2'h0;
    end
    else
    begin
      rc_sync_q <= {rc_sync_q[0], reconfig_request_n_i};
      tck_sync_q <= {tck_sync_q[1:0], tck_i};
      tms_sync_q <= {tms_sync_q[0], tms_i};
      tdi_sync_q <= {tdi_sync_q[0], tdi_i};
    end
  end

  // Step divider pacing the scan at the checker rate.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      div_cnt_q <= 8'h00;
    else if (step || reconfig)
      div_cnt_q <= 8'h00;
    else
      div_cnt_q <= div_cnt_q + 8'h01;
  end

  // Configuration load, user mode entry and the repeated scan.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= ST_CONFIG;
      fcrc_q <= `CMCC_FRAME_INIT;
      scrc_q <= `CMCC_IMAGE_INIT;
      ref_q <= {`CMCC_REF_W{1'b0}};
      wr_ptr_q <= {`CMCC_CELL_AW{1'b0}};
      err_q <= 1'b0;
      cell_wr_o <= 1'b0;
      cell_rd_o <= 1'b0;
      cell_addr_o <= {`CMCC_CELL_AW{1'b0}};
      cell_wdata_o <= {`CMCC_WORD_W{1'b0}};
    end
    else if (reconfig)
    begin
      state_q <= ST_CONFIG;
      fcrc_q <= `CMCC_FRAME_INIT;
      scrc_q <= `CMCC_IMAGE_INIT;
      wr_ptr_q <= {`CMCC_CELL_AW{1'b0}};
      err_q <= 1'b0;
      cell_wr_o <= 1'b0;
      cell_rd_o <= 1'b0;
      cell_addr_o <= {`CMCC_CELL_AW{1'b0}};
    end
    else
    begin
      cell_wr_o <= 1'b0;
      if (ref_upd)
        ref_q <= dr_sh_q;
      case (state_q)
        ST_CONFIG:
        begin
          if (cfg_valid_i && (cfg_kind_i == `CMCC_KIND_DATA))
          begin
            fcrc_q <= fcrc_next;
            cell_wr_o <= 1'b1;
            cell_addr_o <= wr_ptr_q;
            cell_wdata_o <= cfg_data_i[15:0];
            wr_ptr_q <= wr_ptr_q + 1'b1;
          end
          else if (cfg_valid_i && (cfg_kind_i == `CMCC_KIND_FRAME_CRC))
          begin
            fcrc_q <= `CMCC_FRAME_INIT;
            if (fcrc_q != cfg_data_i[15:0])
              state_q <= ST_HALT;
          end
          else if (cfg_valid_i && (cfg_kind_i == `CMCC_KIND_IMAGE_CRC))
          begin
            ref_q <= cfg_data_i;
            state_q <= ST_INIT;
          end
        end
        ST_HALT:
          state_q <= ST_HALT;
        ST_INIT:
        begin
          cell_addr_o <= {`CMCC_CELL_AW{1'b0}};
          scrc_q <= `CMCC_IMAGE_INIT;
          if (check_en_i)
          begin
            state_q <= ST_SCAN;
            cell_rd_o <= 1'b1;
          end
          else
            state_q <= ST_USER;
        end
        ST_USER:
          state_q <= ST_USER;
        ST_SCAN:
        begin
          if (step)
          begin
            if (cell_addr_o == `CMCC_CELL_LAST)
            begin
              // Signature is zero exactly when the pass matches the reference.
              err_q <= ((scrc_next ^ ref_q) != 32'h00000000);
              scrc_q <= `CMCC_IMAGE_INIT;
              cell_addr_o <= {`CMCC_CELL_AW{1'b0}};
            end
            else
            begin
              scrc_q <= scrc_next;
              cell_addr_o <= cell_addr_o + 1'b1;
            end
          end
        end
        default:
          state_q <= ST_CONFIG;
      endcase
    end
  end

  // Scan-chain controller sampled on synchronised clock edges.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tap_q <= TAP_RESET;
      ir_q <= `CMCC_IR_BYPASS;
      ir_sh_q <= {`CMCC_IR_W{1'b0}};
      dr_sh_q <= {`CMCC_REF_W{1'b0}};
    end
    else if (tck_rise)
    begin
      tap_q <= tap_next(tap_q, tms_sync_q[1]);
      case (tap_q)
        TAP_RESET:
          ir_q <= `CMCC_IR_BYPASS;
        TAP_CAP_IR:
          ir_sh_q <= `CMCC_IR_CAPTURE;
        TAP_SH_IR:
          ir_sh_q <= {tdi_sync_q[1], ir_sh_q[`CMCC_IR_W-1:1]};
        TAP_UPD_IR:
          ir_q <= ir_sh_q;
        TAP_CAP_DR:
          // Capture lets the tester read out the present reference.
          dr_sh_q <= ref_sel ? ref_q : {`CMCC_REF_W{1'b0}};
        TAP_SH_DR:
        begin
          if (ref_sel)
            dr_sh_q <= {tdi_sync_q[1], dr_sh_q[`CMCC_REF_W-1:1]};
          else
            dr_sh_q <= {{(`CMCC_REF_W-1){1'b0}}, tdi_sync_q[1]};
        end
        default:
          ir_q <= ir_q;
      endcase
    end
  end

  // Test data out changes on the falling clock edge while shifting.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_o <= (tap_q == TAP_SH_IR) || (tap_q == TAP_SH_DR);
      tdo_o <= (tap_q == TAP_SH_IR) ? ir_sh_q[0] : dr_sh_q[0];
    end
  end

  // Status and error pin drivers.
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      crc_error_o <= 1'b0;
      crc_error_oe_o <= 1'b1;
      config_error_o <= 1'b0;
      user_mode_o <= 1'b0;
    end
    else
    begin
      // Open drain pulls low only while no error; the external pull-up shows an error.
      crc_error_o <= open_drain_en_i ? 1'b0 : err_q;
      crc_error_oe_o <= open_drain_en_i ? ~err_q : 1'b1;
      config_error_o <= (state_q == ST_HALT) && !reconfig;
      user_mode_o <= in_user && !reconfig;
    end
  end

endmodule // cmcc_top

// ===== tb/cmcc_monitor.sv
// Concurrent assertions on the ports of the CRC checker top.
module cmcc_monitor (
  // Clock, reset and inputs
  input wire clk_i,
  input wire rstn_i,
  input wire reconfig_request_n_i,
  input wire cfg_valid_i,
  input wire [1:0] cfg_kind_i,
  input wire [31:0] cfg_data_i,
  input wire check_en_i,
  input wire open_drain_en_i,
  input wire [3:0] div_exp_i,
  // Outputs
  input wire cell_wr_o,
  input wire cell_rd_o,
  input wire [9:0] cell_addr_o,
  input wire [15:0] cell_wdata_o,
  input wire crc_error_o,
  input wire crc_error_oe_o,
  input wire config_error_o,
  input wire user_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_calm;
    reconfig_request_n_i [*3];
  endsequence
  sequence s_cfg;
    !user_mode_o && !config_error_o;
  endsequence
  sequence s_enter;
    !user_mode_o ##1 !user_mode_o ##1 user_mode_o;
  endsequence
  a_data_write: assert property (
    s_calm ##0 s_cfg ##0 (cfg_valid_i && cfg_kind_i == 2'h0)
    |=> cell_wr_o && cell_wdata_o == $past(cfg_data_i[15:0]))
    else $error("data word not written");
  a_image_user: assert property (
    s_calm ##0 s_cfg ##0 (cfg_valid_i && cfg_kind_i == 2'h2) |=> s_enter)
    else $error("user mode not entered on time");
  a_halt_quiet: assert property (
    config_error_o |-> !cell_wr_o && !user_mode_o)
    else $error("activity after frame mismatch");
  a_halt_holds: assert property (
    s_calm ##0 config_error_o |=> config_error_o)
    else $error("halt dropped without reconfiguration");
  a_user_holds: assert property (
    s_calm ##0 user_mode_o |=> user_mode_o)
    else $error("user mode left without reconfiguration");
  a_scan_on: assert property (
    user_mode_o && check_en_i |-> cell_rd_o && !cell_wr_o)
    else $error("scan not running in user mode");
  a_scan_step: assert property (
    cell_rd_o && $past(cell_rd_o) && div_exp_i == 4'h0
    |-> cell_addr_o == $past(cell_addr_o) + 10'h001)
    else $error("scan address skipped");
  a_err_pass_end: assert property (
    user_mode_o && $changed(crc_error_o || !crc_error_oe_o)
    |-> $past(cell_addr_o) == 10'h3FF || $past(cell_addr_o, 2) == 10'h3FF
    || $past(cell_addr_o, 3) == 10'h3FF)
    else $error("error pin changed mid pass");
  a_od_data: assert property (
    open_drain_en_i |-> !crc_error_o)
    else $error("open drain pin driven high");
  a_pp_enable: assert property (
    !open_drain_en_i |-> crc_error_oe_o)
    else $error("push pull pin not enabled");
endmodule // cmcc_monitor

bind cmcc_top cmcc_monitor mon_u (
  .clk_i(clk_i), .rstn_i(rstn_i), .reconfig_request_n_i(reconfig_request_n_i),
  .cfg_valid_i(cfg_valid_i), .cfg_kind_i(cfg_kind_i), .cfg_data_i(cfg_data_i),
  .check_en_i(check_en_i), .open_drain_en_i(open_drain_en_i), .div_exp_i(div_exp_i),
  .cell_wr_o(cell_wr_o), .cell_rd_o(cell_rd_o), .cell_addr_o(cell_addr_o),
  .cell_wdata_o(cell_wdata_o), .crc_error_o(crc_error_o), .crc_error_oe_o(crc_error_oe_o),
  .config_error_o(config_error_o), .user_mode_o(user_mode_o));

// ===== tb/cmcc_host_model.sv
// Far side model: configuration cell memory and boundary-scan test host.
module cmcc_host_model (
  // Clock and cell memory port
  input wire clk_i,
  input wire cell_wr_i,
  input wire [9:0] cell_addr_i,
  input wire [15:0] cell_wdata_i,
  output wire [15:0] cell_rdata_o,
  // Scan pins
  input wire tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:1023];
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 16'h0000;
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  assign cell_rdata_o = mem[cell_addr_i];
  always @(posedge clk_i)
    if (cell_wr_i)
      mem[cell_addr_i] <= cell_wdata_i;
  // Each scan clock half lasts six system clocks to clear the pin synchronisers.
  task automatic tbit(input logic m, input logic d, output logic q);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (6) @(posedge clk_i);
    q = tdo_i;
    tck_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic walk(input logic [31:0] ms, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      tbit(ms[i], 1'b0, q);
  endtask
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] g);
    g = 32'h0;
    for (int i = 0; i < n; i++)
      tbit(i == n - 1, v[i], g[i]);
    walk(32'h1, 2);
  endtask
  task automatic load_ir(input logic [9:0] op);
    logic [31:0] g;
    walk(32'h19F, 11);
    shift({22'h0, op}, 10, g);
  endtask
  // Captured value comes out while the new one goes in, so the old one is saved.
  task automatic scan_dr(input logic [31:0] v, output logic [31:0] g);
    walk(32'h1, 3);
    shift(v, 32, g);
  endtask
endmodule // cmcc_host_model

// ===== tb/config_memory_crc_checker_tb_top.sv
// Self-checking bench of the configuration memory CRC checker.
module config_memory_crc_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rcfg_n = 1'b1;
  logic cfg_valid = 1'b0;
  logic [1:0] cfg_kind = 2'h0;
  logic [31:0] cfg_data = 32'h0;
  logic od_en = 1'b0;
  logic [3:0] dexp = 4'h0;
  logic chk_en = 1'b1;
  logic [31:0] ref_v;
  logic [31:0] got;
  logic [9:0] a0;
  logic [25:0] wq [$];
  logic [15:0] img [0:1023];
  wire cwr, crd, tdo, tdo_oe, err, err_oe, cfg_err, umode, tck, tms, tdi;
  wire [9:0] caddr;
  wire [15:0] cwd;
  wire [15:0] rdat;
  int n_fail = 0;
  int compares = 0;
  int seed = 29710;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  cmcc_top dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .reconfig_request_n_i(rcfg_n),
    .cfg_valid_i(cfg_valid), .cfg_kind_i(cfg_kind), .cfg_data_i(cfg_data),
    .check_en_i(chk_en), .open_drain_en_i(od_en), .div_exp_i(dexp),
    .cell_wr_o(cwr), .cell_rd_o(crd), .cell_addr_o(caddr), .cell_wdata_o(cwd),
    .cell_rdata_i(rdat), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .crc_error_o(err), .crc_error_oe_o(err_oe),
    .config_error_o(cfg_err), .user_mode_o(umode));
  cmcc_host_model host_u (
    .clk_i(clk_i), .cell_wr_i(cwr), .cell_addr_i(caddr), .cell_wdata_i(cwd),
    .cell_rdata_o(rdat), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_wr(input logic [25:0] g, input logic [25:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t cell write %h expected %h", $time, g, e);
    end
  endtask
  // Left-aligned shift register so one routine serves both CRC widths.
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [15:0] d,
                                      input logic [31:0] p);
    for (int i = 15; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? p : 32'h0);
    return c;
  endfunction
  always @(posedge clk_i)
    if (cwr === 1'b1)
      chk_wr({caddr, cwd}, wq.size() > 0 ? wq.pop_front() : 26'h3FFFFFF);
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic send(input logic [1:0] k, input logic [31:0] d);
    cfg_valid <= 1'b1;
    cfg_kind <= k;
    cfg_data <= d;
    @(posedge clk_i);
  endtask
  task automatic configure(input int bad);
    logic [31:0] f;
    logic [15:0] d;
    for (int fr = 0; fr < 3 && fr <= bad; fr++)
    begin
      f = 32'hFFFF0000;
      for (int w = 0; w < 4; w++)
      begin
        d = $random(seed);
        a0 = fr * 4 + w;
        f = crc(f, d, 32'h10210000);
        wq.push_back({a0, d});
        img[a0] = d;
        send(2'h0, {16'h0, d});
      end
      send(2'h1, {16'h0, f[31:16] ^ {15'h0, fr == bad}});
    end
    f = 32'hFFFFFFFF;
    for (int i = 0; i < 1024; i++)
      f = crc(f, img[i], 32'h04C11DB7);
    ref_v = f;
    if (bad > 2)
      send(2'h2, ref_v);
    cfg_valid <= 1'b0;
  endtask
  task automatic wait_err(input logic v, input int lim);
    for (int i = 0; i < lim && (od_en ? !err_oe : err) !== v; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk_v(od_en ? !err_oe : err, v);
  endtask
  task automatic upset();
    host_u.mem[1000] = host_u.mem[1000] ^ 16'h0001;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  initial
  begin
    for (int i = 0; i < 1024; i++)
      img[i] = 16'h0000;
    cycles(6);
    rstn_i <= 1'b1;
    cycles(3);
    configure(9);
    cycles(4);
    chk_v(umode, 1'b1);
    cycles(2100);
    chk_v(err, 1'b0);
    upset();
    wait_err(1'b1, 2100);
    upset();
    cycles(1000);
    chk_v(err, 1'b1);
    wait_err(1'b0, 1100);
    host_u.load_ir(10'h015);
    host_u.scan_dr(~ref_v, got);
    chk_v(got, ref_v);
    chk_v(tdo_oe, 1'b0);
    wait_err(1'b1, 2100);
    host_u.scan_dr(ref_v, got);
    chk_v(got, ~ref_v);
    wait_err(1'b0, 2100);
    rcfg_n <= 1'b0;
    cycles(4);
    rcfg_n <= 1'b1;
    chk_v(umode, 1'b0);
    host_u.load_ir(10'h015);
    host_u.scan_dr(32'h5A5A5A5A, got);
    chk_v(got, 32'hB4B4B4B4);
    configure(1);
    cycles(2);
    chk_v(cfg_err, 1'b1);
    send(2'h0, 32'h1234);
    send(2'h2, ref_v);
    cfg_valid <= 1'b0;
    cycles(5);
    chk_v({cfg_err, umode}, 32'h2);
    rcfg_n <= 1'b0;
    chk_en <= 1'b0;
    cycles(4);
    rcfg_n <= 1'b1;
    cycles(3);
    configure(9);
    cycles(4);
    chk_v({umode, crd}, 32'h2);
    rstn_i <= 1'b0;
    chk_en <= 1'b1;
    od_en <= 1'b1;
    dexp <= 4'h2;
    cycles(6);
    rstn_i <= 1'b1;
    cycles(3);
    configure(9);
    cycles(8);
    a0 = caddr;
    cycles(4);
    chk_v(caddr, a0 + 10'h001);
    upset();
    wait_err(1'b1, 8400);
    chk_v(err, 1'b0);
    end_of_test();
  end
endmodule // config_memory_crc_checker_tb_top
